// [design/asr_pkg.sv]
// Shared constants for the converter result summation and shifter block.
package asr_pkg;
   // Register addresses on the special-function-register bus.
   localparam logic [7:0] ASR_ADDR_CONV_CTRL1 = 8'hdd;
   localparam logic [7:0] ASR_ADDR_DEC_LOW = 8'hde;
   localparam logic [7:0] ASR_ADDR_DEC_HIGH = 8'hdf;
   localparam logic [7:0] ASR_ADDR_SUM_CTRL = 8'he1;
   localparam logic [7:0] ASR_ADDR_SUM_B0 = 8'he2;
   localparam logic [7:0] ASR_ADDR_SUM_B1 = 8'he3;
   localparam logic [7:0] ASR_ADDR_SUM_B2 = 8'he4;
   localparam logic [7:0] ASR_ADDR_SUM_B3 = 8'he5;
   localparam logic [7:0] ASR_ADDR_OFFSET = 8'he6;
   // Reset values.
   localparam logic [7:0] ASR_RST_CONV_CTRL1 = 8'h00;
   localparam logic [7:0] ASR_RST_DEC_LOW = 8'h1b;
   localparam logic [7:0] ASR_RST_DEC_HIGH = 8'h06;
   localparam logic [7:0] ASR_RST_SUM_CTRL = 8'h00;
   localparam logic [7:0] ASR_RST_OFFSET = 8'h00;
   // Field positions in the converter control one register.
   localparam int ASR_OVF_BIT = 7;
   localparam int ASR_POL_BIT = 6;
   localparam int ASR_SM_HI = 5;
   localparam int ASR_SM_LO = 4;
   localparam int ASR_CAL_HI = 2;
   // Field positions in the summation control, decimation high and offset registers.
   localparam int ASR_FUNC_HI = 7;
   localparam int ASR_FUNC_LO = 6;
   localparam int ASR_CNT_HI = 5;
   localparam int ASR_CNT_LO = 3;
   localparam int ASR_SHF_HI = 2;
   localparam int ASR_SHF_LO = 0;
   localparam int ASR_DEC_HIGH_HI = 2;
   localparam int ASR_OFS_SIGN_BIT = 7;
   // Arithmetic function codes.
   localparam logic [1:0] ASR_FUNC_CPU = 2'b00;
   localparam logic [1:0] ASR_FUNC_ACC = 2'b01;
   localparam logic [1:0] ASR_FUNC_SHIFT = 2'b10;
   localparam logic [1:0] ASR_FUNC_ACC_SHIFT = 2'b11;
   localparam logic [2:0] ASR_CPU_ADD_CNT = 3'h2;
   localparam logic [2:0] ASR_CPU_SUB_CNT = 3'h4;
   // Fixed prescale between converter clock and decimator.
   localparam int ASR_PRESCALE = 64;
   // Calibration modes.
   typedef enum logic [2:0] {
      ASR_CAL_NONE = 3'h0,
      ASR_CAL_SELF_BOTH = 3'h1,
      ASR_CAL_SELF_OFS = 3'h2,
      ASR_CAL_SELF_GAIN = 3'h3,
      ASR_CAL_SYS_OFS = 3'h4,
      ASR_CAL_SYS_GAIN = 3'h5,
      ASR_CAL_RSV6 = 3'h6,
      ASR_CAL_RSV7 = 3'h7
   } asr_cal_t;
   // Converter summation sequencer, Gray coded along idle, accumulate, shift.
   typedef enum logic [1:0] {
      ASR_ST_IDLE = 2'b00,
      ASR_ST_ACCUM = 2'b01,
      ASR_ST_SHIFT = 2'b11
   } asr_state_t;
endpackage : asr_pkg

// [design/asr_rate_div.sv]
// Result-rate divider: converter clock over 64, then over the decimation ratio.
`timescale 1ns/1ps
`default_nettype none
module asr_rate_div
   import asr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic run,
   input wire logic [10:0] ratio,
   output logic strobe_r
);
   logic [5:0] pre_r;
   logic [10:0] dec_r;
   logic pre_wrap;

   assign pre_wrap = (pre_r == 6'(ASR_PRESCALE - 1));

   // Prescaler and decimation counter; both park while the converter is off.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         pre_r <= 6'h00;
         dec_r <= 11'h000;
         strobe_r <= 1'b0;
      end else if (clk_en) begin
         strobe_r <= 1'b0;
         if (!run) begin
            pre_r <= 6'h00;
            dec_r <= 11'h000;
         end else begin
            pre_r <= pre_r + 6'h01;
            if (pre_wrap) begin
               if (dec_r + 11'h001 >= ratio) begin
                  dec_r <= 11'h000;
                  strobe_r <= 1'b1;
               end else begin
                  dec_r <= dec_r + 11'h001;
               end
            end
         end
      end
   end
endmodule : asr_rate_div
`default_nettype wire

// [design/asr_top.sv]
// Converter control, decimation, summation/shifter and offset injection registers.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Calibration field write starts calibration, reads zero.
// - Calibration codes: none, self, system, reserved.
// - Eleven-bit decimation ratio across two registers.
// - Result rate is clock/64/decimation ratio.
// - Sum held cleared while converter powered down.
// - Writing zero control clears whole sum.
// - Bipolar mode sign-extends accumulated values.
// - Function 00 count 010 adds on write.
// - Function 00 count 100 subtracts on write.
// - Function 10 only shifts the sum.
// - Function 01 accumulates results without shifting.
// - Function 11 accumulates, then shifts right.
// - Count field selects 2 to 256 results.
// - Summation completion raises interrupt unless masked.
// - Reading byte zero clears completion interrupt.
// - Byte zero write triggers four-byte arithmetic.
// - Shift field selects shift of 1 to 8.
// - Sum exposed as four consecutive bytes.
// - Offset 00h or 80h disables injection.
// - Offset bit7 sign, six-to-zero magnitude.
// - Sticky overflow flag, cleared by writing zero.
// - Polarity bit: 0 bipolar, 1 unipolar.
module asr_top
   import asr_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic adc_power_down,
   input wire logic sum_irq_mask,
   input wire logic adc_valid,
   input wire logic [23:0] adc_result,
   output logic cal_start,
   output logic [2:0] cal_mode,
   output logic [10:0] decimation_ratio,
   output logic conv_strobe,
   output logic [7:0] offset_code,
   output logic offset_enable,
   output logic result_polarity,
   output logic sum_irq
);
   logic [7:0] ctrl1_r;
   logic [7:0] dec_low_r;
   logic [7:0] dec_high_r;
   logic [7:0] ssc_r;
   logic [7:0] ofs_r;
   logic [31:0] sum_r;
   logic [31:8] opnd_r;
   logic [8:0] cnt_r;
   logic done_r;
   logic ovf_set;
   asr_state_t state_r;

   logic wr_ctrl1, wr_ssc, wr_b0, rd_b0;
   logic bipolar;
   logic [1:0] func_w;
   logic [8:0] target;
   logic [3:0] shf_amt;
   logic [31:0] opnd_full;
   logic [31:0] res_ext;
   logic [32:0] add_wide;
   logic [31:0] acc_sum;
   logic done_set;
   logic cpu_add, cpu_sub;

   assign wr_ctrl1 = clk_en && sfr_wr && (sfr_addr == ASR_ADDR_CONV_CTRL1);
   assign wr_ssc = clk_en && sfr_wr && (sfr_addr == ASR_ADDR_SUM_CTRL);
   assign wr_b0 = clk_en && sfr_wr && (sfr_addr == ASR_ADDR_SUM_B0);
   assign rd_b0 = clk_en && sfr_rd && (sfr_addr == ASR_ADDR_SUM_B0);
   assign bipolar = !ctrl1_r[ASR_POL_BIT];
   assign func_w = ssc_r[ASR_FUNC_HI:ASR_FUNC_LO];
   assign target = 9'h002 << ssc_r[ASR_CNT_HI:ASR_CNT_LO];
   assign shf_amt = {1'b0, ssc_r[ASR_SHF_HI:ASR_SHF_LO]} + 4'h1;
   assign opnd_full = {opnd_r, sfr_wdata};
   assign cpu_add = (func_w == ASR_FUNC_CPU) && (ssc_r[ASR_CNT_HI:ASR_CNT_LO] == ASR_CPU_ADD_CNT)
      && (ssc_r[ASR_SHF_HI:ASR_SHF_LO] == 3'h0);
   assign cpu_sub = (func_w == ASR_FUNC_CPU) && (ssc_r[ASR_CNT_HI:ASR_CNT_LO] == ASR_CPU_SUB_CNT)
      && (ssc_r[ASR_SHF_HI:ASR_SHF_LO] == 3'h0);
   // Converter results widen by sign in bipolar mode and by zeros otherwise.
   assign res_ext = bipolar ? {{8{adc_result[23]}}, adc_result} : {8'h00, adc_result};
   assign add_wide = {1'b0, sum_r} + {1'b0, res_ext};
   assign acc_sum = add_wide[31:0];

   // Right shift that keeps the sign of a bipolar sum.
   function automatic logic [31:0] asr_shr(input logic [31:0] v, input logic [3:0] n,
                                           input logic sgn);
      logic [31:0] r;
      r = sgn ? 32'($signed(v) >>> n) : (v >> n);
      return r;
   endfunction : asr_shr

   // Overflow detection for an add or subtract under the active number format.
   function automatic logic asr_ovf(input logic [31:0] a, input logic [31:0] b,
                                    input logic [31:0] s, input logic sub, input logic sgn);
      logic o;
      if (sgn) begin
         o = sub ? ((a[31] != b[31]) && (s[31] != a[31]))
                 : ((a[31] == b[31]) && (s[31] != a[31]));
      end else begin
         o = sub ? (b > a) : (s < a);
      end
      return o;
   endfunction : asr_ovf

   // Result-rate divider that paces converter results.
   asr_rate_div u_rate (
      .mclk(mclk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .run(!adc_power_down),
      .ratio(decimation_ratio),
      .strobe_r(conv_strobe)
   );

   // Converter control one: polarity, settling mode, calibration start and overflow flag.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl1_r <= ASR_RST_CONV_CTRL1;
         cal_start <= 1'b0;
         cal_mode <= ASR_CAL_NONE;
      end else if (clk_en) begin
         cal_start <= wr_ctrl1;
         if (wr_ctrl1) begin
            ctrl1_r[ASR_POL_BIT:ASR_SM_LO] <= sfr_wdata[ASR_POL_BIT:ASR_SM_LO];
            cal_mode <= sfr_wdata[ASR_CAL_HI:0];
         end
         // A new overflow in the clearing cycle keeps the flag set.
         if (ovf_set) begin
            ctrl1_r[ASR_OVF_BIT] <= 1'b1;
         end else if (wr_ctrl1 && !sfr_wdata[ASR_OVF_BIT]) begin
            ctrl1_r[ASR_OVF_BIT] <= 1'b0;
         end
      end
   end

   // Decimation ratio and offset injection registers.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         dec_low_r <= ASR_RST_DEC_LOW;
         dec_high_r <= ASR_RST_DEC_HIGH;
         ofs_r <= ASR_RST_OFFSET;
      end else if (clk_en && sfr_wr) begin
         if (sfr_addr == ASR_ADDR_DEC_LOW) begin
            dec_low_r <= sfr_wdata;
         end
         if (sfr_addr == ASR_ADDR_DEC_HIGH) begin
            dec_high_r <= {5'h00, sfr_wdata[ASR_DEC_HIGH_HI:0]};
         end
         if (sfr_addr == ASR_ADDR_OFFSET) begin
            ofs_r <= sfr_wdata;
         end
      end
   end

   // Registered copies of the configuration driven to the analog side.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         decimation_ratio <= {ASR_RST_DEC_HIGH[ASR_DEC_HIGH_HI:0], ASR_RST_DEC_LOW};
         offset_code <= ASR_RST_OFFSET;
         offset_enable <= 1'b0;
         result_polarity <= 1'b0;
      end else if (clk_en) begin
         decimation_ratio <= {dec_high_r[ASR_DEC_HIGH_HI:0], dec_low_r};
         offset_code <= ofs_r;
         offset_enable <= (ofs_r[ASR_OFS_SIGN_BIT-1:0] != 7'h00);
         result_polarity <= ctrl1_r[ASR_POL_BIT];
      end
   end

   // Summation control register and the upper operand bytes.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ssc_r <= ASR_RST_SUM_CTRL;
         opnd_r <= 24'h000000;
      end else if (clk_en && sfr_wr) begin
         if (sfr_addr == ASR_ADDR_SUM_CTRL) begin
            ssc_r <= sfr_wdata;
         end
         if (sfr_addr == ASR_ADDR_SUM_B1) begin
            opnd_r[15:8] <= sfr_wdata;
         end
         if (sfr_addr == ASR_ADDR_SUM_B2) begin
            opnd_r[23:16] <= sfr_wdata;
         end
         if (sfr_addr == ASR_ADDR_SUM_B3) begin
            opnd_r[31:24] <= sfr_wdata;
         end
      end
   end

   // Summation datapath and converter-summation sequencer.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sum_r <= 32'h00000000;
         cnt_r <= 9'h000;
         state_r <= ASR_ST_IDLE;
         ovf_set <= 1'b0;
         done_set <= 1'b0;
      end else if (clk_en) begin
         ovf_set <= 1'b0;
         done_set <= 1'b0;
         if (adc_power_down) begin
            sum_r <= 32'h00000000;
            cnt_r <= 9'h000;
            state_r <= ASR_ST_IDLE;
         end else if (wr_ssc) begin
            cnt_r <= 9'h000;
            state_r <= ASR_ST_IDLE;
            if (sfr_wdata == 8'h00) begin
               sum_r <= 32'h00000000;
            end else if (sfr_wdata[ASR_FUNC_HI:ASR_FUNC_LO] == ASR_FUNC_SHIFT) begin
               sum_r <= asr_shr(sum_r, {1'b0, sfr_wdata[ASR_SHF_HI:ASR_SHF_LO]} + 4'h1,
                                bipolar);
            end else if (sfr_wdata[ASR_FUNC_LO]) begin
               state_r <= ASR_ST_ACCUM;
            end
         end else if (wr_b0 && cpu_add) begin
            sum_r <= sum_r + opnd_full;
            ovf_set <= asr_ovf(sum_r, opnd_full, sum_r + opnd_full, 1'b0, bipolar);
         end else if (wr_b0 && cpu_sub) begin
            sum_r <= sum_r - opnd_full;
            ovf_set <= asr_ovf(sum_r, opnd_full, sum_r - opnd_full, 1'b1, bipolar);
         end else begin
            case (state_r)
               ASR_ST_IDLE: begin
                  cnt_r <= cnt_r;
               end
               ASR_ST_ACCUM: begin
                  if (adc_valid) begin
                     sum_r <= acc_sum;
                     ovf_set <= asr_ovf(sum_r, res_ext, acc_sum, 1'b0, bipolar);
                     cnt_r <= cnt_r + 9'h001;
                     if (cnt_r + 9'h001 == target) begin
                        if (func_w == ASR_FUNC_ACC_SHIFT) begin
                           state_r <= ASR_ST_SHIFT;
                        end else begin
                           state_r <= ASR_ST_IDLE;
                           done_set <= 1'b1;
                        end
                     end
                  end
               end
               ASR_ST_SHIFT: begin
                  sum_r <= asr_shr(sum_r, shf_amt, bipolar);
                  state_r <= ASR_ST_IDLE;
                  done_set <= 1'b1;
               end
               default: begin
                  state_r <= ASR_ST_IDLE;
               end
            endcase
         end
      end
   end

   // Sticky completion flag; a completion in the read cycle is not lost.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         done_r <= 1'b0;
         sum_irq <= 1'b0;
      end else if (clk_en) begin
         if (done_set) begin
            done_r <= 1'b1;
         end else if (rd_b0) begin
            done_r <= 1'b0;
         end
         sum_irq <= done_r && !sum_irq_mask;
      end
   end

   // Registered read data; unmapped addresses read as zero.
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         sfr_rdata <= 8'h00;
      end else if (clk_en) begin
         sfr_rdata <= 8'h00;
         if (sfr_rd) begin
            case (sfr_addr)
               ASR_ADDR_CONV_CTRL1: sfr_rdata <= {ctrl1_r[ASR_OVF_BIT:ASR_SM_LO], 4'h0};
               ASR_ADDR_DEC_LOW: sfr_rdata <= dec_low_r;
               ASR_ADDR_DEC_HIGH: sfr_rdata <= dec_high_r;
               ASR_ADDR_SUM_CTRL: sfr_rdata <= ssc_r;
               ASR_ADDR_SUM_B0: sfr_rdata <= sum_r[7:0];
               ASR_ADDR_SUM_B1: sfr_rdata <= sum_r[15:8];
               ASR_ADDR_SUM_B2: sfr_rdata <= sum_r[23:16];
               ASR_ADDR_SUM_B3: sfr_rdata <= sum_r[31:24];
               ASR_ADDR_OFFSET: sfr_rdata <= ofs_r;
               default: sfr_rdata <= 8'h00;
            endcase
         end
      end
   end

   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   // Named events: a processor add fired by a byte-zero write, and a byte-zero read with no completion in that cycle.
   sequence s_cpu_add_write;
      wr_b0 && cpu_add && !adc_power_down;
   endsequence
   sequence s_b0_read;
      rd_b0 && !done_set;
   endsequence

   property p_cal_read_zero;
      clk_en && sfr_rd && sfr_addr == ASR_ADDR_CONV_CTRL1 |=> sfr_rdata[2:0] == 3'h0;
   endproperty
   a_cal_read_zero: assert property (p_cal_read_zero) else $error("cal field read not zero");
   property p_cal_start;
      wr_ctrl1 |=> cal_start && cal_mode == $past(sfr_wdata[2:0]);
   endproperty
   a_cal_start: assert property (p_cal_start) else $error("calibration not started");
   property p_pd_clear;
      clk_en && adc_power_down |=> sum_r == 32'h00000000;
   endproperty
   a_pd_clear: assert property (p_pd_clear) else $error("sum not held clear");
   property p_zero_clear;
      wr_ssc && sfr_wdata == 8'h00 |=> sum_r == 32'h00000000;
   endproperty
   a_zero_clear: assert property (p_zero_clear) else $error("sum not cleared");
   property p_cpu_add;
      s_cpu_add_write |=> sum_r == $past(sum_r) + $past(opnd_full);
   endproperty
   a_cpu_add: assert property (p_cpu_add) else $error("cpu add wrong");
   property p_irq_clear;
      s_b0_read |=> !done_r ##1 !sum_irq || !clk_en;
   endproperty
   a_irq_clear: assert property (p_irq_clear) else $error("irq not cleared");
   property p_irq_raise;
      clk_en && done_set && !sum_irq_mask ##1 clk_en && !sum_irq_mask |=> sum_irq;
   endproperty
   a_irq_raise: assert property (p_irq_raise) else $error("irq not raised");
   property p_ofs_off;
      clk_en && ofs_r[6:0] == 7'h00 |=> !offset_enable;
   endproperty
   a_ofs_off: assert property (p_ofs_off) else $error("offset not disabled");
   property p_restart;
      wr_ssc && !adc_power_down |=> cnt_r == 9'h000;
   endproperty
   a_restart: assert property (p_restart) else $error("count not restarted");
endmodule : asr_top
`default_nettype wire

// [verif/asr_cpu_model.sv]
// Processor-side model that issues special-function-register cycles.
`timescale 1ns/1ps
`default_nettype none
module asr_cpu_model (
   input wire logic mclk,
   input wire logic [7:0] sfr_rdata,
   output var logic [7:0] sfr_addr,
   output var logic [7:0] sfr_wdata,
   output var logic sfr_wr,
   output var logic sfr_rd
);
   int gap = 0;
   // The bus starts idle with both strobes low.
   initial begin
      sfr_addr = 8'h00;
      sfr_wdata = 8'h00;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
   end
   // Opens a cycle just after an edge; gap adds idle cycles for a slow core.
   task automatic start(input logic [7:0] a, input logic [7:0] d);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      #1;
      sfr_addr = a;
      sfr_wdata = d;
   endtask : start
   // Closes a cycle one edge later and scrambles the released lines.
   task automatic end_cycle();
      @(posedge mclk);
      #1;
      sfr_wr = 1'b0;
      sfr_rd = 1'b0;
      sfr_addr = ~sfr_addr;
      sfr_wdata = ~sfr_wdata;
   endtask : end_cycle
   // A write strobe held for exactly one taking edge.
   task automatic write(input logic [7:0] a, input logic [7:0] d);
      start(a, d);
      sfr_wr = 1'b1;
      end_cycle();
   endtask : write
   // Read data is taken in the cycle after the strobe.
   task automatic read(input logic [7:0] a, output logic [7:0] d);
      start(a, ~a);
      sfr_rd = 1'b1;
      end_cycle();
      d = sfr_rdata;
   endtask : read
endmodule : asr_cpu_model
`default_nettype wire

// [verif/asr_top_test.sv]
// Self-checking bench for the converter summation and shifter block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      err_count++; \
      $display("MISMATCH %s expected %h seen %h", nm, e, g); \
   end \
end
module asr_top_test;
   import asr_pkg::*;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic clk_en = 1'b1;
   logic adc_power_down = 1'b0;
   logic sum_irq_mask = 1'b0;
   logic adc_valid = 1'b0;
   logic [23:0] adc_result = 24'h000000;
   logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, offset_code, rd_v;
   logic sfr_wr, sfr_rd, cal_start, conv_strobe, offset_enable, result_polarity, sum_irq;
   logic [2:0] cal_mode;
   logic [10:0] decimation_ratio;
   logic [31:0] sum_v;
   int err_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int n;
   // Reset table, the last address unmapped, and offset codes to try.
   logic [7:0] ra [9] = '{8'hde, 8'hdf, 8'he1, 8'he2, 8'he3, 8'he4, 8'he5, 8'he6, 8'he0};
   logic [7:0] rv [9] = '{8'h1b, 8'h06, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   logic [7:0] ov [4] = '{8'h00, 8'h80, 8'h81, 8'h7f};
   // Free-running 25 MHz clock.
   always #20 mclk = ~mclk;
   // Design and processor model.
   asr_top DUT (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
      .adc_power_down(adc_power_down), .sum_irq_mask(sum_irq_mask),
      .adc_valid(adc_valid), .adc_result(adc_result), .cal_start(cal_start),
      .cal_mode(cal_mode), .decimation_ratio(decimation_ratio), .conv_strobe(conv_strobe),
      .offset_code(offset_code), .offset_enable(offset_enable),
      .result_polarity(result_polarity), .sum_irq(sum_irq));
   asr_cpu_model cpu (.mclk(mclk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr),
      .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd));
   // Reads one register and compares it.
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] e);
      cpu.read(a, rd_v);
      `CHK(nm, e, rd_v)
   endtask : rchk
   // Reads the four sum bytes, lowest address first.
   task automatic read_sum();
      for (int i = 0; i < 4; i++) begin
         cpu.read(8'he2 + 8'(i), rd_v);
         sum_v[8*i +: 8] = rd_v;
      end
   endtask : read_sum
   // Sets the control byte, loads the operand and fires it with the lowest byte.
   task automatic cpu_op(input logic [7:0] cfg, input logic [31:0] v);
      cpu.write(8'he1, cfg);
      cpu.write(8'he5, v[31:24]);
      cpu.write(8'he4, v[23:16]);
      cpu.write(8'he3, v[15:8]);
      cpu.write(8'he2, v[7:0]);
   endtask : cpu_op
   // Converter results: one-cycle valid pulses, data scrambled between them.
   task automatic feed(input int k, input logic [23:0] r);
      repeat (k) begin
         @(posedge mclk);
         #1;
         adc_valid = 1'b1;
         adc_result = r;
         @(posedge mclk);
         #1;
         adc_valid = 1'b0;
         adc_result = ~r;
         @(posedge mclk);
         #1;
      end
   endtask : feed
   // Bounded wait for the completion request.
   task automatic wait_irq();
      n = 0;
      while (sum_irq !== 1'b1 && n < 8) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask : wait_irq
   // Counts cycles to the next rate strobe.
   task automatic to_strobe();
      n = 0;
      @(posedge mclk);
      #1;
      while (conv_strobe !== 1'b1 && n < 1000) begin
         @(posedge mclk);
         #1;
         n++;
      end
   endtask : to_strobe
   // One converter summation from a cleared sum.
   task automatic acc_run(input logic [7:0] cfg, input int k, input logic [23:0] r,
                          input logic [31:0] e);
      cpu.write(8'he1, 8'h00);
      cpu.write(8'he1, cfg);
      feed(k - 1, r);
      `CHK("irq early", 1'b0, sum_irq)
      feed(1, r);
      wait_irq();
      `CHK("irq", 1'b1, sum_irq)
      read_sum();
      `CHK("sum", e, sum_v)
      `CHK("irq ack", 1'b0, sum_irq)
   endtask : acc_run
   // Prints the counts and the verdict, then stops.
   task automatic end_of_test();
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : end_of_test
   // Main sequence.
   initial begin
      repeat (6) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      `CHK("ratio reset", 11'h61b, decimation_ratio)
      cpu.write(8'he0, 8'hff);
      for (int i = 0; i < 9; i++) begin
         rchk("reset value", ra[i], rv[i]);
      end
      cpu.write(8'hde, 8'ha5);
      cpu.write(8'hdf, 8'hfd);
      // The ratio output is a registered copy, so it follows one edge after the write.
      @(posedge mclk);
      #1;
      `CHK("ratio", 11'h5a5, decimation_ratio)
      rchk("ratio low", 8'hde, 8'ha5);
      for (int i = 0; i < 4; i++) begin
         cpu.write(8'he6, ov[i]);
         @(posedge mclk);
         #1;
         `CHK("offset code", ov[i], offset_code)
         `CHK("offset on", |ov[i][6:0], offset_enable)
      end
      @(posedge mclk);
      #1;
      clk_en = 1'b0;
      cpu.write(8'he6, 8'h33);
      clk_en = 1'b1;
      rchk("frozen write", 8'he6, 8'h7f);
      cpu.write(8'he6, 8'h00);
      for (int c = 0; c < 8; c++) begin
         cpu.write(8'hdd, 8'(c));
         `CHK("cal start", 1'b1, cal_start)
         `CHK("cal mode", 3'(c), cal_mode)
         cpu.read(8'hdd, rd_v);
         `CHK("cal readback", 3'h0, rd_v[2:0])
         `CHK("cal pulse", 1'b0, cal_start)
      end
      cpu.write(8'he1, 8'h00);
      cpu_op(8'h10, 32'h12345678);
      read_sum();
      `CHK("add", 32'h12345678, sum_v)
      cpu_op(8'h20, 32'h00000079);
      read_sum();
      `CHK("subtract", 32'h123455ff, sum_v)
      cpu.write(8'he1, 8'h00);
      read_sum();
      `CHK("clear", 32'h0, sum_v)
      cpu.gap = 2;
      for (int k = 0; k < 8; k++) begin
         cpu.write(8'he1, 8'h00);
         cpu_op(8'h10, 32'h00010000);
         cpu.write(8'he1, 8'hb8 | 8'(k));
         read_sum();
         `CHK("shift", 32'h00010000 >> (k + 1), sum_v)
      end
      cpu.gap = 0;
      cpu_op(8'h10, 32'h00000055);
      cpu.write(8'hde, 8'h02);
      cpu.write(8'hdf, 8'h00);
      @(posedge mclk);
      #1;
      adc_power_down = 1'b1;
      read_sum();
      `CHK("powered down sum", 32'h0, sum_v)
      adc_power_down = 1'b0;
      to_strobe();
      to_strobe();
      `CHK("strobe spacing", 64 * 2 - 1, n)
      acc_run(8'h40, 2, 24'hfffffe, 32'hfffffffc);
      acc_run(8'h78, 256, 24'h000001, 32'h00000100);
      acc_run(8'hc0, 2, 24'h000011, 32'h00000011);
      cpu.write(8'hdd, 8'h40);
      @(posedge mclk);
      #1;
      `CHK("polarity", 1'b1, result_polarity)
      acc_run(8'h40, 2, 24'hfffffe, 32'h01fffffc);
      cpu.write(8'hdd, 8'h00);
      cpu.write(8'he1, 8'h40);
      feed(1, 24'h000004);
      cpu.write(8'he1, 8'h40);
      feed(1, 24'h000004);
      `CHK("restart", 1'b0, sum_irq)
      feed(1, 24'h000004);
      wait_irq();
      `CHK("restart done", 1'b1, sum_irq)
      cpu.read(8'he2, rd_v);
      sum_irq_mask = 1'b1;
      cpu.write(8'he1, 8'h40);
      feed(2, 24'h000004);
      repeat (4) @(posedge mclk);
      #1;
      `CHK("masked", 1'b0, sum_irq)
      cpu.read(8'he2, rd_v);
      sum_irq_mask = 1'b0;
      // A signed add past the top of the range sets the sticky flag, and writing zero clears it.
      cpu.write(8'he1, 8'h00);
      cpu_op(8'h10, 32'h7fffffff);
      cpu_op(8'h10, 32'h00000001);
      rchk("overflow set", 8'hdd, 8'h80);
      cpu.write(8'hdd, 8'h00);
      rchk("overflow clear", 8'hdd, 8'h00);
      end_of_test();
   end
   // Cuts a hung run short.
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 20000) begin
         err_count++;
         end_of_test();
      end
   end
endmodule : asr_top_test
`default_nettype wire
